/* src/two_wire_regs.svh */
`ifndef TWO_WIRE_REGS_SVH
`define TWO_WIRE_REGS_SVH
// Register offsets on the plain register port
`define ADDR_CONTROL 3'h0
`define ADDR_STATUS 3'h1
`define ADDR_DATA 3'h2
`define ADDR_OWN 3'h3
`define ADDR_MASK 3'h4
// Control register bit positions
`define CTL_DONE 7
`define CTL_ACKEN 6
`define CTL_START 5
`define CTL_STOP 4
`define CTL_COLL 3
`define CTL_EN 2
`define CTL_IE 0
// Reset values
`define RST_STATUS_CODE 5'h1F
`define RST_DATA 8'hFF
`define RST_OWN 8'hFE
`define RST_MASK 7'h00
// Status codes (upper five bits of status)
`define ST_START 5'h01
`define ST_SLA_ACK 5'h03
`define ST_SLA_NACK 5'h04
`define ST_DATA_ACK 5'h05
`define ST_DATA_NACK 5'h06
`define ST_IDLE 5'h1F
// Quarter-bit step in system clocks, less one (divider reload value)
`define HALF_BIT_CYCLES 8'd50
`endif

/* src/two_wire_pkg.sv */
`default_nettype none
package two_wire_pkg;
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_WAIT_FREE = 7'h02,
        S_START = 7'h04,
        S_HOLD = 7'h08,
        S_BITS = 7'h10,
        S_ACK = 7'h20,
        S_STOP = 7'h40
    } phase_e;
    typedef struct packed {
        logic [6:0] ctl;
        logic [4:0] code;
        logic [1:0] presc;
        logic [7:0] data;
        logic [7:0] own;
        logic [6:0] mask;
    } regs_s;
    typedef struct packed {
        logic scl_out;
        logic sda_out;
    } pins_s;
endpackage : two_wire_pkg
`default_nettype wire

/* src/two_wire_addr_mask_and_handshake.sv */
// Implementation choices: the register offsets and the strobed register port.
`include "two_wire_regs.svh"
`default_nettype none
// Operation
// - Mask bits 7..1 exclude matching address bits from own-address compare.
// - Mask register bit 0 always reads zero.
// - Job-done flag rises after each bus event, one byte at a time.
// - Interrupt follows flag only with unit and global enables set.
// - Status holds a code describing unit state while flag set.
// - No operation while flag set; clearing launches the selected operation.
// - Flag cleared by writing one to its control bit.
// - After START sent, set flag and post START code.
// - After address sent, set flag and post code with acknowledge state.
// - After data sent, set flag and post code with acknowledge state.
// - After STOP sent, flag stays clear, no event.
// - While flag set, bus clock held low. The code releases it while enable is clear.
// - Status reads five-bit code high, prescaler in low two bits.
// - Own-address holds seven-bit address high, general call enable low.
// - START request waits for free bus, then produces START.
module two_wire_addr_mask_and_handshake #(
    parameter logic [7:0] HALF_BIT = `HALF_BIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Interrupt
    input wire logic global_irq_en_i,
    output logic irq_o,
    // Bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Received address match
    input wire logic [6:0] rx_addr_i,
    output logic addr_match_o
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        two_wire_pkg::regs_s r;
        two_wire_pkg::phase_e ph;
        logic [7:0] tick;
        logic [1:0] q;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic is_addr;
        logic bus_busy;
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_p;
        logic sda_p;
        two_wire_pkg::pins_s pins;
        logic [7:0] rdata;
    } state_s;
    state_s s_q, s_d;

    function automatic logic masked_match(input logic [6:0] a, input logic [6:0] own, input logic [6:0] m);
        masked_match = &(m | ~(a ^ own));
    endfunction : masked_match

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic done_set;
        logic [4:0] post;
        logic step;
        done_set = 1'b0;
        post = s_q.r.code;
        s_d = s_q;
        step = 1'b0;
        s_d.scl_s = {s_q.scl_s[0], scl_i};
        s_d.sda_s = {s_q.sda_s[0], sda_i};
        s_d.scl_p = s_q.scl_s[1];
        s_d.sda_p = s_q.sda_s[1];
        // Bus busy tracking from START/STOP seen
        if (s_q.scl_s[1] && s_q.sda_p && !s_q.sda_s[1])
            s_d.bus_busy = 1'b1;
        if (s_q.scl_s[1] && !s_q.sda_p && s_q.sda_s[1])
            s_d.bus_busy = 1'b0;
        // Quarter-bit divider
        if (s_q.tick == 8'h00)
        begin
            s_d.tick = HALF_BIT;
            step = 1'b1;
        end
        else
            s_d.tick = s_q.tick - 8'h01;
        // Read data stand for one cycle only, zero otherwise
        s_d.rdata = 8'h00;
        // Register reads, one cycle later
        if (rd_i)
        begin
            unique case (addr_i)
                `ADDR_CONTROL: s_d.rdata = {s_q.r.ctl[6:1], 1'b0, s_q.r.ctl[0]};
                `ADDR_STATUS: s_d.rdata = {s_q.r.code, 1'b0, s_q.r.presc};
                `ADDR_DATA: s_d.rdata = s_q.r.data;
                `ADDR_OWN: s_d.rdata = s_q.r.own;
                `ADDR_MASK: s_d.rdata = {s_q.r.mask, 1'b0};
                default: s_d.rdata = 8'h00;
            endcase
        end
        // Register writes
        // Done clear and hardware set may meet in one cycle: set applied last
        if (wr_i)
        begin
            unique case (addr_i)
                `ADDR_CONTROL:
                begin
                    s_d.r.ctl[`CTL_ACKEN-1] = wdata_i[`CTL_ACKEN];
                    s_d.r.ctl[`CTL_START-1] = wdata_i[`CTL_START];
                    s_d.r.ctl[`CTL_STOP-1] = wdata_i[`CTL_STOP];
                    s_d.r.ctl[`CTL_EN-1] = wdata_i[`CTL_EN];
                    s_d.r.ctl[`CTL_IE] = wdata_i[`CTL_IE];
                    if (wdata_i[`CTL_DONE])
                        s_d.r.ctl[`CTL_DONE-1] = 1'b0;
                end
                `ADDR_STATUS: s_d.r.presc = wdata_i[1:0];
                // Data writable only while waiting, else collision
                `ADDR_DATA:
                begin
                    if (s_q.r.ctl[`CTL_DONE-1])
                    begin
                        s_d.r.data = wdata_i;
                        s_d.r.ctl[`CTL_COLL-1] = 1'b0;
                    end
                    else
                        s_d.r.ctl[`CTL_COLL-1] = 1'b1;
                end
                `ADDR_OWN: s_d.r.own = wdata_i;
                `ADDR_MASK: s_d.r.mask = wdata_i[7:1];
                default: s_d.r.own = s_q.r.own;
            endcase
        end
        // Bus sequencer, runs only while flag clear
        // Clearing enable aborts any transfer and releases both lines
        if (!s_q.r.ctl[`CTL_EN-1])
        begin
            s_d.ph = two_wire_pkg::S_IDLE;
            s_d.pins = '{scl_out: 1'b1, sda_out: 1'b1};
        end
        else if (step)
        begin
            unique case (s_q.ph)
                two_wire_pkg::S_IDLE, two_wire_pkg::S_HOLD:
                begin
                    if (!s_q.r.ctl[`CTL_DONE-1])
                    begin
                        if (s_q.r.ctl[`CTL_START-1])
                            s_d.ph = two_wire_pkg::S_WAIT_FREE;
                        else if (s_q.ph == two_wire_pkg::S_HOLD && s_q.r.ctl[`CTL_STOP-1])
                        begin
                            s_d.ph = two_wire_pkg::S_STOP;
                            s_d.q = 2'd0;
                        end
                        else if (s_q.ph == two_wire_pkg::S_HOLD)
                        begin
                            s_d.ph = two_wire_pkg::S_BITS;
                            s_d.shreg = s_q.r.data;
                            s_d.bitn = 4'd0;
                            s_d.q = 2'd0;
                        end
                    end
                end
                two_wire_pkg::S_WAIT_FREE:
                    if (!s_q.bus_busy || s_q.ph == two_wire_pkg::S_WAIT_FREE && s_q.pins.scl_out == 1'b0)
                    begin
                        s_d.ph = two_wire_pkg::S_START;
                        s_d.pins.scl_out = 1'b1;
                        s_d.pins.sda_out = 1'b1;
                        s_d.q = 2'd0;
                    end
                // Start: data falls while clock high, then clock low
                two_wire_pkg::S_START:
                begin
                    s_d.q = s_q.q + 2'd1;
                    if (s_q.q == 2'd1)
                        s_d.pins.sda_out = 1'b0;
                    if (s_q.q == 2'd2)
                    begin
                        s_d.pins.scl_out = 1'b0;
                        done_set = 1'b1;
                        post = `ST_START;
                        s_d.is_addr = 1'b1;
                        s_d.ph = two_wire_pkg::S_HOLD;
                    end
                end
                // Bit slot: set data, raise clock, sample, lower clock
                // Ninth slot releases data and reads the acknowledge
                two_wire_pkg::S_BITS, two_wire_pkg::S_ACK:
                begin
                    s_d.q = s_q.q + 2'd1;
                    unique case (s_q.q)
                        2'd0: s_d.pins.sda_out = (s_q.ph == two_wire_pkg::S_ACK) ? 1'b1 : s_q.shreg[7];
                        2'd1: s_d.pins.scl_out = 1'b1;
                        2'd2: if (s_q.ph == two_wire_pkg::S_BITS) s_d.shreg = {s_q.shreg[6:0], s_q.sda_s[1]};
                        default:
                        begin
                            s_d.pins.scl_out = 1'b0;
                            if (s_q.ph == two_wire_pkg::S_ACK)
                            begin
                                done_set = 1'b1;
                                post = s_q.is_addr ? (s_q.sda_s[1] ? `ST_SLA_NACK : `ST_SLA_ACK)
                                                   : (s_q.sda_s[1] ? `ST_DATA_NACK : `ST_DATA_ACK);
                                s_d.r.data = s_q.shreg;
                                s_d.is_addr = 1'b0;
                                s_d.ph = two_wire_pkg::S_HOLD;
                            end
                            else if (s_q.bitn == 4'd7)
                                s_d.ph = two_wire_pkg::S_ACK;
                            else
                                s_d.bitn = s_q.bitn + 4'd1;
                        end
                    endcase
                end
                // Stop: data low, clock high, then data released
                two_wire_pkg::S_STOP:
                begin
                    s_d.q = s_q.q + 2'd1;
                    unique case (s_q.q)
                        2'd0: s_d.pins.sda_out = 1'b0;
                        2'd1: s_d.pins.scl_out = 1'b1;
                        2'd2: s_d.pins.sda_out = 1'b1;
                        default:
                        begin
                            s_d.r.ctl[`CTL_STOP-1] = 1'b0;
                            s_d.r.code = `ST_IDLE;
                            s_d.ph = two_wire_pkg::S_IDLE;
                        end
                    endcase
                end
                default: s_d.ph = two_wire_pkg::S_IDLE;
            endcase
        end
        // flag set with status code, set wins over clear
        if (done_set)
        begin
            s_d.r.ctl[`CTL_DONE-1] = 1'b1;
            s_d.r.code = post;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            s_q <= '0;
            s_q.r.code <= `RST_STATUS_CODE;
            s_q.r.data <= `RST_DATA;
            s_q.r.own <= `RST_OWN;
            s_q.r.mask <= `RST_MASK;
            s_q.ph <= two_wire_pkg::S_IDLE;
            s_q.pins <= '{scl_out: 1'b1, sda_out: 1'b1};
            s_q.scl_s <= 2'b11;
            s_q.sda_s <= 2'b11;
            s_q.scl_p <= 1'b1;
            s_q.sda_p <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata_o = s_q.rdata;
    assign irq_o = s_q.r.ctl[`CTL_DONE-1] & s_q.r.ctl[`CTL_IE] & global_irq_en_i;
    // clock held low while flag and enable set
    assign scl_o = 1'b0;
    assign scl_oe_n_o = ~(s_q.r.ctl[`CTL_EN-1] & (~s_q.pins.scl_out | s_q.r.ctl[`CTL_DONE-1]));
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~(s_q.r.ctl[`CTL_EN-1] & ~s_q.pins.sda_out);
    assign addr_match_o = masked_match(rx_addr_i, s_q.r.own[7:1], s_q.r.mask);
endmodule : two_wire_addr_mask_and_handshake
`default_nettype wire

/* test/two_wire_monitor.sv */
`include "two_wire_regs.svh"
`default_nettype none
module two_wire_monitor (
    // Clock, reset and register port
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Interrupt and bus enables
    input wire logic global_irq_en_i,
    input wire logic irq_o,
    input wire logic scl_oe_n_o,
    input wire logic sda_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Control writes that launch a start or a stop
    sequence s_launch;
        wr_i && addr_i == `ADDR_CONTROL && wdata_i[`CTL_DONE] && wdata_i[`CTL_START] && wdata_i[`CTL_EN]
            && wdata_i[`CTL_IE] && global_irq_en_i;
    endsequence
    sequence s_stop;
        wr_i && addr_i == `ADDR_CONTROL && wdata_i[`CTL_DONE] && wdata_i[`CTL_STOP] && !wdata_i[`CTL_START]
            && wdata_i[`CTL_EN];
    endsequence
    // Flag, stretch and status relations
    property p_gate; irq_o |-> global_irq_en_i; endproperty
    a_gate: assert property (p_gate) else $error("irq without global enable");
    property p_stretch; irq_o |-> !scl_oe_n_o; endproperty
    a_stretch: assert property (p_stretch) else $error("clock not held low");
    property p_idle; irq_o && $past(irq_o) && !wr_i |=> $stable(sda_oe_n_o); endproperty
    a_idle: assert property (p_idle) else $error("data line moved while waiting");
    property p_mask0; rd_i && addr_i == `ADDR_MASK |=> !rdata_o[0]; endproperty
    a_mask0: assert property (p_mask0) else $error("mask bit 0 not zero");
    property p_stat2; rd_i && addr_i == `ADDR_STATUS |=> !rdata_o[2]; endproperty
    a_stat2: assert property (p_stat2) else $error("status bit 2 not zero");
    property p_code; rd_i && addr_i == `ADDR_STATUS && irq_o |=> rdata_o[7:3] != `ST_IDLE; endproperty
    a_code: assert property (p_code) else $error("idle code while flag set");
    property p_start; s_launch |-> ##[1:400] irq_o; endproperty
    a_start: assert property (p_start) else $error("start never completed");
    property p_stop; s_stop |=> !irq_o [*8]; endproperty
    a_stop: assert property (p_stop) else $error("flag raised by stop");
endmodule : two_wire_monitor
`default_nettype wire

/* test/two_wire_slave_model.sv */
`default_nettype none
module two_wire_slave_model (
    // Bus wires
    input wire logic scl_i,
    input wire logic sda_i,
    // Acknowledge choice and captured bytes
    input wire logic ack_en_i,
    output logic sda_pull_o,
    output logic [7:0] byte_o,
    output int count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int bits = 0;
    initial
    begin
        sda_pull_o = 1'b0;
        byte_o = 8'h00;
        count_o = 0;
    end
    // Start condition restarts the bit count
    always @(negedge sda_i)
        if (scl_i) bits = 0;
    // Bits shift in MSB first
    always @(posedge scl_i)
    begin
        if (bits < 8) byte_o = {byte_o[6:0], sda_i};
        bits = (bits == 8) ? 0 : bits + 1;
        if (bits == 8) count_o++;
    end
    // Ninth slot acknowledge, released after
    always @(negedge scl_i)
        sda_pull_o = (bits == 8) && ack_en_i;
endmodule : two_wire_slave_model
`default_nettype wire

/* test/tb_top.sv */
`include "two_wire_regs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, global_irq_en_i = 1, ack_en = 1, rd_d = 0;
    logic [2:0] addr_i = 0;
    logic [6:0] rx_addr_i = 0;
    logic [7:0] wdata_i = 0, rdata_o, own, msk, dat, sbyte, expq[$], byteq[$];
    logic irq_o, scl_o, sda_o, scl_oe_n_o, sda_oe_n_o, addr_match_o, sda_pull, scl_w, sda_w;
    int sbytes, seen_b = 0, failures = 0, total_checks = 0, seed = 4;
    always #25 mclk_i = ~mclk_i;
    // Open-drain wires with pull-ups
    assign scl_w = scl_oe_n_o | scl_o;
    assign sda_w = (sda_oe_n_o | sda_o) & ~sda_pull;
    two_wire_addr_mask_and_handshake #(.HALF_BIT(8'd1)) dut (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .global_irq_en_i, .irq_o, .scl_i(scl_w), .sda_i(sda_w), .scl_o, .scl_oe_n_o, .sda_o,
        .sda_oe_n_o, .rx_addr_i, .addr_match_o);
    two_wire_slave_model slave (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en), .sda_pull_o(sda_pull),
        .byte_o(sbyte), .count_o(sbytes));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge mclk_i);
    endtask : bus
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd
    task automatic await(input logic [4:0] code);
        for (int n = 0; n < 400 && irq_o !== 1'b1; n++) @(posedge mclk_i);
        check({7'h0, irq_o}, 8'h01);
        rd(`ADDR_STATUS, {code, 3'h0});
    endtask : await
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    // Read data and bytes on the wire against the notes
    always @(posedge mclk_i)
    begin
        if (rd_d) check(rdata_o, expq.pop_front());
        rd_d <= rd_i;
        if (sbytes != seen_b)
        begin
            seen_b = sbytes;
            check(sbyte, byteq.pop_front());
        end
    end
    // Hang guard
    initial
    begin
        #200000;
        failures++;
        conclude();
    end
    // Main sequence
    initial
    begin
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(`ADDR_MASK, 8'h00);
        rd(`ADDR_OWN, 8'hFE);
        rd(`ADDR_STATUS, 8'hF8);
        rd(`ADDR_DATA, 8'hFF);
        bus(1'b1, 3'h7, 8'hFF);
        rd(3'h7, 8'h00);
        own = 8'($random(seed));
        msk = 8'($random(seed));
        bus(1'b1, `ADDR_OWN, own);
        bus(1'b1, `ADDR_MASK, msk);
        rd(`ADDR_MASK, {msk[7:1], 1'b0});
        rd(`ADDR_OWN, own);
        repeat (24)
        begin
            rx_addr_i <= 7'($random(seed));
            global_irq_en_i <= 1'($random(seed));
            @(negedge mclk_i);
            check({7'h0, addr_match_o}, {7'h0, &(msk[7:1] | ~(rx_addr_i ^ own[7:1]))});
            @(posedge mclk_i);
        end
        global_irq_en_i <= 1'b1;
        bus(1'b1, `ADDR_CONTROL, 8'hA5);
        await(`ST_START);
        dat = 8'($random(seed)) & 8'hFE;
        bus(1'b1, `ADDR_DATA, dat);
        byteq.push_back(dat);
        rd(`ADDR_DATA, dat);
        // launch address with start request zero
        bus(1'b1, `ADDR_CONTROL, 8'h85);
        bus(1'b1, `ADDR_DATA, 8'h5A);
        rd(`ADDR_CONTROL, 8'h0D);
        await(`ST_SLA_ACK);
        global_irq_en_i <= 1'b0;
        @(posedge mclk_i);
        check({7'h0, irq_o}, 8'h00);
        global_irq_en_i <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            dat = 8'($random(seed));
            bus(1'b1, `ADDR_DATA, dat);
            byteq.push_back(dat);
            rd(`ADDR_CONTROL, 8'h85);
            ack_en = (i == 0);
            bus(1'b1, `ADDR_CONTROL, 8'h85);
            await(i == 0 ? `ST_DATA_ACK : `ST_DATA_NACK);
        end
        bus(1'b1, `ADDR_CONTROL, 8'h95);
        repeat (60) @(posedge mclk_i);
        check({7'h0, irq_o}, 8'h00);
        rd(`ADDR_STATUS, 8'hF8);
        rd(`ADDR_CONTROL, 8'h05);
        repeat (3) @(posedge mclk_i);
        conclude();
    end
endmodule : tb_top
bind two_wire_addr_mask_and_handshake two_wire_monitor mon (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .global_irq_en_i, .irq_o, .scl_oe_n_o, .sda_oe_n_o);
`default_nettype wire
